// ---- design/nbalu_top.sv ----
// nibble alu: temp operands, arithmetic, logic, tests, rotate, flags
// assumes decoder holds op and destination stable with the strobe
`timescale 1ns/1ps
module nbalu_top
  import nbalu_pkg::*;
#(
  // operand width; the flag logic is built around one nibble
  parameter int WIDTH = NBALU_W
) (
  // clock, reset, enable
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST_N,
  input  wire logic       I_CE,
  // instruction request
  input  wire logic       I_START,
  input  wire logic [3:0] I_OP,
  input  wire logic [3:0] I_OPND_A,
  input  wire logic [3:0] I_OPND_B,
  // status word software access, one nibble per address
  input  wire logic       I_PSW_WE,
  input  wire logic [6:0] I_PSW_ADDR,
  input  wire logic [3:0] I_PSW_WDATA,
  // result
  output logic            O_DONE,
  output logic [3:0]      O_RESULT,
  output logic            O_STORE,
  output logic            O_SKIP,
  output logic            O_BUSY,
  // flags and status word view
  output logic [3:0]      O_FLAGS,
  output logic [3:0]      O_PSW_RDATA
);
  // one-hot control state
  nbalu_state_t state_reg;
  nbalu_state_t state_next;
  logic [3:0]   tmp_a_reg;
  logic [3:0]   tmp_b_reg;
  nbalu_op_t    op_reg;
  logic [3:0]   flags_reg;
  logic [3:0]   flags_next;
  logic [3:0]   result_reg;
  logic         done_reg;
  logic         store_reg;
  logic         skip_reg;

  // ports and flag layout are fixed at one nibble
  if (WIDTH != NBALU_W) begin : g_width_check
    $error("nbalu_top serves a width of 4 only");
  end

  // zero test shared by the SKF, SKE and SKNE skips and the zero flag
  function automatic logic nib_is_zero(input logic [3:0] v);
    return v == NBALU_ZERO_NIB;
  endfunction

  // both status nibbles map onto the same four flags
  function automatic logic psw_addr_hit(input logic [6:0] addr);
    return (addr == NBALU_PSW_HI_ADDR) || (addr == NBALU_PSW_LO_ADDR);
  endfunction

  // named views of the shared flag register
  wire zero_f  = flags_reg[NBALU_F_ZERO];
  wire carry_f = flags_reg[NBALU_F_CARRY];
  wire inhib_f = flags_reg[NBALU_F_INHIB];
  wire dec_f   = flags_reg[NBALU_F_DEC];

  // state decodes shared by flag, operand and pulse logic
  wire in_exec  = state_reg == NBALU_ST_EXEC;
  wire take     = (state_reg == NBALU_ST_IDLE) && I_START;

  // op class decodes
  wire is_add   = (op_reg == NBALU_OP_ADD) || (op_reg == NBALU_OP_ADDC);
  wire is_sub   = (op_reg == NBALU_OP_SUB) || (op_reg == NBALU_OP_SUBC);
  wire is_arith = is_add || is_sub;
  wire use_cin  = (op_reg == NBALU_OP_ADDC) || (op_reg == NBALU_OP_SUBC);
  wire cin      = use_cin & carry_f;
  wire is_cmp   = (op_reg == NBALU_OP_SKE) || (op_reg == NBALU_OP_SKNE) ||
                  (op_reg == NBALU_OP_SKGE) || (op_reg == NBALU_OP_SKLT);
  wire is_bit   = (op_reg == NBALU_OP_SKT) || (op_reg == NBALU_OP_SKF);
  // software access decode
  wire psw_hit  = I_PSW_WE && psw_addr_hit(I_PSW_ADDR);

  // binary sum/difference with carry/borrow as bit 4
  wire [4:0] bin_sum  = {1'b0, tmp_a_reg} + {1'b0, tmp_b_reg} + {4'h0, cin};
  wire [4:0] bin_diff = {1'b0, tmp_a_reg} - {1'b0, tmp_b_reg} - {4'h0, cin};

  // decimal correction adds six to sums of ten or more and subtracts six on a borrow
  wire       add_fix  = bin_sum >= NBALU_DEC_TEN;
  wire [4:0] add_adj  = bin_sum + NBALU_DEC_SIX;
  wire       sub_fix  = bin_diff[4];
  wire [4:0] sub_adj  = bin_diff - NBALU_DEC_SIX;
  // high sums wrap past the adjust; forcing 1010B keeps them out of digit range
  wire       add_high = bin_sum >= NBALU_DEC_HIGH_SUM;
  wire [3:0] add_low  = add_fix ? add_adj[3:0] : bin_sum[3:0];
  wire [3:0] dec_add  = add_high ? (add_adj[3:0] | NBALU_DEC_OVER) : add_low;
  wire [3:0] dec_sub  = sub_fix ? sub_adj[3:0] : bin_diff[3:0];
  wire [3:0] ar_res   = dec_f ? (is_add ? dec_add : dec_sub)
                              : (is_add ? bin_sum[3:0] : bin_diff[3:0]);
  wire       ar_cy    = is_add ? (dec_f ? add_fix : bin_sum[4]) : bin_diff[4];
  // compares ignore carry and never touch the flags
  wire [3:0] cmp_diff = tmp_a_reg - tmp_b_reg;
  wire       cmp_brw  = tmp_a_reg < tmp_b_reg;

  // result, store and skip per op; unused codes store nothing
  logic [3:0] res_c;
  logic       store_c;
  logic       skip_c;
  always_comb begin
    res_c   = NBALU_ZERO_NIB;
    store_c = 1'b0;
    skip_c  = 1'b0;
    case (op_reg)
      NBALU_OP_ADD, NBALU_OP_ADDC, NBALU_OP_SUB, NBALU_OP_SUBC: begin
        res_c   = ar_res;
        store_c = ~inhib_f;
      end
      NBALU_OP_OR: begin
        res_c   = tmp_a_reg | tmp_b_reg;
        store_c = 1'b1;
      end
      NBALU_OP_AND: begin
        res_c   = tmp_a_reg & tmp_b_reg;
        store_c = 1'b1;
      end
      NBALU_OP_XOR: begin
        res_c   = tmp_a_reg ^ tmp_b_reg;
        store_c = 1'b1;
      end
      NBALU_OP_SKT:  skip_c = (tmp_a_reg & tmp_b_reg) == tmp_b_reg;
      NBALU_OP_SKF:  skip_c = nib_is_zero(tmp_a_reg & tmp_b_reg);
      NBALU_OP_SKE:  skip_c = nib_is_zero(cmp_diff);
      NBALU_OP_SKNE: skip_c = !nib_is_zero(cmp_diff);
      NBALU_OP_SKGE: skip_c = ~cmp_brw;
      NBALU_OP_SKLT: skip_c = cmp_brw;
      NBALU_OP_ROT: begin
        res_c   = {carry_f, tmp_a_reg[3:1]};
        store_c = 1'b1;
      end
      default: ;
    endcase
  end

  // flag update; software write to the status word wins over a same-cycle op
  always_comb begin
    flags_next = flags_reg;
    if (in_exec) begin
      if (is_arith) begin
        flags_next[NBALU_F_CARRY] = ar_cy;
        // inhibited zero result keeps the old zero so chained compares accumulate
        if (!nib_is_zero(ar_res))
          flags_next[NBALU_F_ZERO] = 1'b0;
        else
          flags_next[NBALU_F_ZERO] = zero_f | ~inhib_f;
      end else if (op_reg == NBALU_OP_ROT) begin
        flags_next[NBALU_F_CARRY] = tmp_a_reg[0];
      end else if (is_bit) begin
        flags_next[NBALU_F_INHIB] = 1'b0;
      end
      // logic and compare ops fall through holding all flags
    end
    // a flag written by software is never lost to an op in the same cycle
    if (psw_hit)
      flags_next = I_PSW_WDATA;
  end

  // one exec cycle per op; no op needs more
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      NBALU_ST_IDLE: if (I_START) state_next = NBALU_ST_EXEC;
      NBALU_ST_EXEC: state_next = NBALU_ST_IDLE;
      default:       state_next = NBALU_ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= NBALU_ST_IDLE;
      flags_reg <= NBALU_FLAGS_RST;
      tmp_a_reg <= NBALU_ZERO_NIB;
      tmp_b_reg <= NBALU_ZERO_NIB;
      op_reg    <= NBALU_OP_ADD;
    end else if (I_CE) begin
      state_reg <= state_next;
      flags_reg <= flags_next;
      // operands caught on the take; the decoder may move them after
      if (take) begin
        tmp_a_reg <= I_OPND_A;
        tmp_b_reg <= I_OPND_B;
        // unused op codes decode to no action and hold every flag
        op_reg    <= nbalu_op_t'(I_OP);
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      result_reg <= NBALU_ZERO_NIB;
      done_reg   <= 1'b0;
      store_reg  <= 1'b0;
      skip_reg   <= 1'b0;
    end else if (I_CE) begin
      // pulses drop every idle cycle so the decoder sees each once
      done_reg  <= in_exec;
      store_reg <= in_exec & store_c;
      skip_reg  <= in_exec & skip_c;
      if (in_exec)
        result_reg <= res_c;
    end
  end

  assign O_DONE      = done_reg;
  assign O_RESULT    = result_reg;
  assign O_STORE     = store_reg;
  assign O_SKIP      = skip_reg;
  // busy straight from state so a request during exec is refused at once
  assign O_BUSY      = state_reg != NBALU_ST_IDLE;
  // both status nibbles read the one flag register
  assign O_FLAGS     = flags_reg;
  assign O_PSW_RDATA = flags_reg;
endmodule

// ---- design/nbalu_pkg.sv ----
// nibble alu flag logic: shared constants and operation codes
// assumes one core clock and a decoder that issues one op per strobe
package nbalu_pkg;
  localparam int NBALU_W = 4;
  // status word nibble addresses in system register space
  localparam logic [6:0] NBALU_PSW_HI_ADDR = 7'h7E;
  localparam logic [6:0] NBALU_PSW_LO_ADDR = 7'h7F;
  // flag positions inside the 4-bit flag vector
  localparam int NBALU_F_ZERO   = 0;
  localparam int NBALU_F_CARRY  = 1;
  localparam int NBALU_F_INHIB  = 2;
  localparam int NBALU_F_DEC    = 3;
  localparam logic [3:0] NBALU_FLAGS_RST = 4'h0;
  localparam logic [3:0] NBALU_ZERO_NIB  = 4'h0;
  localparam logic [4:0] NBALU_DEC_SIX   = 5'h06;
  localparam logic [4:0] NBALU_DEC_TEN   = 5'h0A;
  // decimal sums from here on must store a value of 1010B or more
  localparam logic [4:0] NBALU_DEC_HIGH_SUM = 5'h14;
  localparam logic [3:0] NBALU_DEC_OVER     = 4'hA;

  typedef enum logic [3:0] {
    NBALU_OP_ADD  = 4'h0,
    NBALU_OP_ADDC = 4'h1,
    NBALU_OP_SUB  = 4'h2,
    NBALU_OP_SUBC = 4'h3,
    NBALU_OP_OR   = 4'h4,
    NBALU_OP_AND  = 4'h5,
    NBALU_OP_XOR  = 4'h6,
    NBALU_OP_SKT  = 4'h7,
    NBALU_OP_SKF  = 4'h8,
    NBALU_OP_SKE  = 4'h9,
    NBALU_OP_SKNE = 4'hA,
    NBALU_OP_SKGE = 4'hB,
    NBALU_OP_SKLT = 4'hC,
    NBALU_OP_ROT  = 4'hD
  } nbalu_op_t;

  typedef enum logic [1:0] {
    NBALU_ST_IDLE = 2'b01,
    NBALU_ST_EXEC = 2'b10
  } nbalu_state_t;
endpackage

// ---- verification/nbalu_assertions.sv ----
// checker: flag, store and timing relations at the alu ports
// assumes clock enable held high and no status writes around a take
`timescale 1ns/1ps
module nbalu_assertions (
  input wire logic       I_CLOCK,
  input wire logic       I_RST_N,
  input wire logic       I_START,
  input wire logic [3:0] I_OP,
  input wire logic [3:0] I_OPND_A,
  input wire logic       I_PSW_WE,
  input wire logic       O_DONE,
  input wire logic       O_BUSY,
  input wire logic       O_STORE,
  input wire logic [3:0] O_RESULT,
  input wire logic [3:0] O_FLAGS
);
  logic [3:0] op_q;
  logic [3:0] a_q;
  // own copy of the take, since the decoder drops it afterwards
  always_ff @(posedge I_CLOCK) begin
    if (I_START && !O_BUSY) begin
      op_q <= I_OP;
      a_q  <= I_OPND_A;
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  sequence s_exec;
    O_BUSY ##1 O_DONE;
  endsequence
  a_take_to_done: assert property (I_START && !O_BUSY |=> s_exec)
    else $error("done not two cycles after take");
  a_flags_idle_hold: assert property (!O_DONE && !$past(I_PSW_WE) |-> $stable(O_FLAGS))
    else $error("flags moved without op or write");
  a_logic_keeps_flags: assert property (O_DONE && op_q inside {[4:6], [9:12]}
    && !$past(I_PSW_WE) |-> $stable(O_FLAGS))
    else $error("logic or compare changed flags");
  a_test_clears_inhib: assert property (O_DONE && op_q inside {7, 8}
    && !$past(I_PSW_WE) |-> !O_FLAGS[2])
    else $error("bit test left store inhibit set");
  a_inhib_blocks_store: assert property (O_DONE && op_q < 4
    |-> O_STORE == !$past(O_FLAGS[2]))
    else $error("arithmetic store does not follow inhibit");
  a_other_ops_store: assert property (O_DONE && op_q inside {[4:6], 13} |-> O_STORE)
    else $error("logic or rotate result not stored");
  a_zero_flag_rule: assert property (O_DONE && op_q < 4 && !$past(I_PSW_WE)
    |-> O_FLAGS[0] == (O_RESULT == 0 && (!$past(O_FLAGS[2]) || $past(O_FLAGS[0]))))
    else $error("zero flag wrong after arithmetic");
  a_rotate_carry: assert property (O_DONE && op_q == 13 && !$past(I_PSW_WE)
    |-> O_RESULT == {$past(O_FLAGS[1]), a_q[3:1]} && O_FLAGS[1] == a_q[0])
    else $error("rotate through carry wrong");
endmodule
bind nbalu_top nbalu_assertions nbalu_assertions_i (.*);

// ---- verification/nbalu_seq_model.sv ----
// sequencer model: issues one alu op per call, as the decoder would
// assumes the alu is idle when a call starts
`timescale 1ns/1ps
module nbalu_seq_model (
  input  wire logic       i_clock,
  input  wire logic       i_done,
  output logic            o_start,
  output logic [3:0]      o_op,
  output logic [3:0]      o_a,
  output logic [3:0]      o_b
);
  initial begin
    o_start = 1'b0;
    o_op = 4'h0;
    o_a = 4'h0;
    o_b = 4'h0;
  end
  task automatic issue(input logic [3:0] op, a, b);
    @(negedge i_clock);
    o_start = 1'b1;
    o_op = op;
    o_a = a;
    o_b = b;
    @(negedge i_clock);
    o_start = 1'b0;
    // flipped once taken, so a late operand read shows
    o_a = ~a;
    o_b = ~b;
    while (i_done !== 1'b1) @(negedge i_clock);
  endtask
endmodule

// ---- verification/nbalu_top_test.sv ----
// bench: ops through the sequencer model, results and flags checked
// assumes clock enable tied high; gating is not exercised
`timescale 1ns/1ps
module nbalu_top_test;
  import nbalu_pkg::*;
  logic       I_CLOCK, I_RST_N, I_PSW_WE, I_START, O_DONE, O_STORE, O_SKIP, O_BUSY;
  logic [3:0] I_OP, I_OPND_A, I_OPND_B, I_PSW_WDATA, O_RESULT, O_FLAGS, O_PSW_RDATA;
  logic [6:0] I_PSW_ADDR;
  int         n_errors = 0, comparisons = 0, cycles = 0;
  nbalu_top nbalu_top_i (.*, .I_CE(1'b1));
  nbalu_seq_model nbalu_seq_model_i (.i_clock(I_CLOCK), .i_done(O_DONE), .o_start(I_START),
    .o_op(I_OP), .o_a(I_OPND_A), .o_b(I_OPND_B));
  task automatic chk(input string nm, input logic [4:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic psw(input logic [6:0] ad, input logic [3:0] d);
    @(negedge I_CLOCK);
    I_PSW_WE = 1'b1;
    I_PSW_ADDR = ad;
    I_PSW_WDATA = d;
    @(negedge I_CLOCK);
    I_PSW_WE = 1'b0;
    I_PSW_WDATA = ~d;
  endtask
  // carry in the top bit, result below
  task automatic run(input logic [3:0] op, a, b, input logic [4:0] exp);
    nbalu_seq_model_i.issue(op, a, b);
    chk("carry_result", exp, {O_FLAGS[1], O_RESULT});
  endtask
  task automatic t_binary;
    psw(7'h7E, 4'h0);
    run(NBALU_OP_ADD, 4'h9, 4'h7, 5'h10);
    chk("zero", 5'h01, O_FLAGS[0]);
    run(NBALU_OP_ADDC, 4'h3, 4'h4, 5'h08);
    run(NBALU_OP_SUB, 4'h2, 4'h3, 5'h1F);
    run(NBALU_OP_SUBC, 4'h5, 4'h2, 5'h02);
    $display("binary test done");
  endtask
  task automatic t_inhibit;
    psw(7'h7F, 4'h5);
    run(NBALU_OP_SUB, 4'h4, 4'h4, 5'h00);
    chk("store", 5'h00, O_STORE);
    chk("zero", 5'h01, O_FLAGS[0]);
    run(NBALU_OP_ADD, 4'h1, 4'h0, 5'h01);
    chk("zero", 5'h00, O_FLAGS[0]);
    run(NBALU_OP_SKT, 4'hF, 4'h3, 5'h00);
    chk("skip", 5'h01, O_SKIP);
    chk("inhibit", 5'h00, O_FLAGS[2]);
    $display("inhibit test done");
  endtask
  task automatic t_decimal;
    psw(7'h7E, 4'h8);
    run(NBALU_OP_ADD, 4'h7, 4'h8, 5'h15);
    run(NBALU_OP_SUB, 4'h3, 4'h5, 5'h18);
    nbalu_seq_model_i.issue(NBALU_OP_ADD, 4'hF, 4'h5);
    chk("high_range", 5'h01, O_RESULT >= 4'hA);
    // carry is now set, so this reaches the top sum of 31
    nbalu_seq_model_i.issue(NBALU_OP_ADDC, 4'hF, 4'hF);
    chk("high_sum", 5'h01, O_RESULT >= 4'hA);
    nbalu_seq_model_i.issue(NBALU_OP_SUB, 4'h0, 4'hF);
    chk("low_diff", 5'h01, O_RESULT >= 4'hA);
    psw(7'h7E, 4'h2);
    run(NBALU_OP_ROT, 4'h6, 4'h0, 5'h0B);
    $display("decimal and rotate test done");
  endtask
  task automatic t_others;
    psw(7'h7F, 4'hF);
    for (int k = 4; k < 13; k++) begin
      if (k != 7 && k != 8) begin
        nbalu_seq_model_i.issue(k[3:0], 4'h5, 4'h5);
        chk("flags", 5'h0F, O_FLAGS);
      end
    end
    run(NBALU_OP_AND, 4'hC, 4'hA, 5'h18);
    nbalu_seq_model_i.issue(NBALU_OP_SKE, 4'h5, 4'h5);
    chk("skip", 5'h01, O_SKIP);
    chk("busy", 5'h00, O_BUSY);
    psw(7'h10, 4'h0);
    chk("psw_read", 5'h0F, O_PSW_RDATA);
    psw(7'h7F, 4'h3);
    chk("flags", 5'h03, O_FLAGS);
    $display("logic compare and status test done");
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    I_CLOCK = 1'b0;
    forever #12.5 I_CLOCK = ~I_CLOCK;
  end
  // about 85 cycles expected
  always @(posedge I_CLOCK) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    I_RST_N = 1'b0;
    I_PSW_WE = 1'b0;
    I_PSW_ADDR = 7'h00;
    I_PSW_WDATA = 4'h0;
    repeat (5) @(negedge I_CLOCK);
    I_RST_N = 1'b1;
    t_binary();
    t_inhibit();
    t_decimal();
    t_others();
    close_out();
  end
endmodule
